/* File: hdl/xbpa_crossbar.sv */
`timescale 1ns/1ps
module xbpa_crossbar
    import xbpa_pkg::*;
#(
    parameter int PDIV = PERIPH_DIV
)
(
    input  wire logic                  core_clk_i,
    input  wire logic                  nrst_i,
    input  wire logic [NM-1:0]         m_req_i,
    input  wire logic [NM-1:0]         m_we_i,
    input  wire logic [NM-1:0][31:0]   m_addr_i,
    input  wire logic [NM-1:0][31:0]   m_wdata_i,
    output logic      [NM-1:0]         m_done_o,
    output logic      [NM-1:0]         m_err_o,
    output logic      [NM-1:0][31:0]   m_rdata_o,
    input  wire logic                  page_we_i,
    input  wire logic                  page_en_i,
    input  wire logic [15:0]           page_base_i,
    output logic                       page_en_o,
    output logic      [15:0]           page_base_o,
    input  wire logic                  cpu_da_req_i,
    input  wire logic                  cpu_db_req_i,
    input  wire logic                  fetch_req_i,
    output logic      [MEM_SRCS-1:0]   mem_gnt_o,
    output logic                       sys_req_o,
    output logic                       sys_we_o,
    output logic      [31:0]           sys_addr_o,
    output logic      [31:0]           sys_wdata_o,
    input  wire logic [31:0]           sys_rdata_i,
    output logic                       per_ce_o,
    output logic                       per_req_o,
    output logic                       per_we_o,
    output logic      [31:0]           per_addr_o,
    output logic      [31:0]           per_wdata_o,
    input  wire logic                  per_ack_i,
    input  wire logic [31:0]           per_rdata_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Types and helpers

    xbpa_top_st_t s_q;
    xbpa_top_st_t s_d;

    logic [NM-1:0]         req_eff;
    logic [NM-1:0]         is_per;
    logic [NM-1:0]         bad;
    logic [NT-1:0][NM-1:0] tr_req;
    logic [NT-1:0][NM-1:0] own;
    logic [NT-1:0]         start;
    logic [NT-1:0]         ack;
    logic [NT-1:0]         step;
    logic [MEM_SRCS-1:0]   src_req;
    logic [MEM_SRCS-1:0]   gnt;
    logic [NT-1:0][31:0]   trdata;
    logic                  in_page;

    function automatic logic [1:0] own_idx(input logic [NM-1:0] o);
        logic [1:0] k;
        k = 2'h0;
        for (int i = 0; i < NM; i++)
        begin
            if (o[i])
                k = 2'(i);
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Path decode

    // A master must drop its request in the cycle after its done or error pulse.
    assign req_eff = m_req_i & ~s_q.done & ~s_q.err;

    assign in_page = !s_q.page_en
        || (m_addr_i[M_HOST][PAGE_MSB:PAGE_LSB] == s_q.page_base);

    always_comb
    begin
        for (int m = 0; m < NM; m++)
        begin
            is_per[m] = (m_addr_i[m][31:28] == PER_REGION);
        end
        bad[M_CPU]   = !is_per[M_CPU];
        bad[M_HOST]  = is_per[M_HOST] || !in_page;
        bad[M_ACCEL] = 1'b0;
        for (int m = 0; m < NM; m++)
        begin
            tr_req[T_MEM][m] = req_eff[m] && !bad[m] && !is_per[m];
            tr_req[T_PER][m] = req_eff[m] && !bad[m] && is_per[m];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Target arbiters

    assign step[T_MEM] = 1'b1;
    assign step[T_PER] = s_q.pce;

    assign ack[T_MEM]    = s_q.treq[T_MEM] && gnt[SRC_SYS];
    assign ack[T_PER]    = s_q.treq[T_PER] && per_ack_i && s_q.pce;
    assign trdata[T_MEM] = sys_rdata_i;
    assign trdata[T_PER] = per_rdata_i;

    genvar t;
    generate
        for (t = 0; t < NT; t++)
        begin : g_tgt
            xbpa_tgt_arb u_arb (
                .core_clk_i (core_clk_i),
                .nrst_i     (nrst_i),
                .req_i      (tr_req[t]),
                .step_i     (step[t]),
                .done_i     (ack[t]),
                .own_o      (own[t]),
                .start_o    (start[t])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Memory controller

    assign src_req[SRC_SYS]   = s_q.treq[T_MEM];
    assign src_req[SRC_DA]    = cpu_da_req_i;
    assign src_req[SRC_DB]    = cpu_db_req_i;
    assign src_req[SRC_FETCH] = fetch_req_i;

    xbpa_memsel u_mem (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .req_i      (src_req),
        .gnt_o      (gnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State update

    always_comb
    begin
        logic [1:0] k;
        k = 2'h0;
        s_d = s_q;
        s_d.done = '0;
        // A request that already owns a target is not refused if the page moves under it.
        s_d.err  = bad & req_eff & ~(own[T_MEM] | own[T_PER]);
        if (s_q.div >= DIV_W'(PDIV - 1))
        begin
            s_d.div = '0;
            s_d.pce = 1'b1;
        end
        else
        begin
            s_d.div = s_q.div + DIV_W'(1);
            s_d.pce = 1'b0;
        end
        if (page_we_i)
        begin
            s_d.page_base = page_base_i;
            s_d.page_en   = page_en_i;
        end
        for (int i = 0; i < NT; i++)
        begin
            if (start[i])
            begin
                k = own_idx(own[i]);
                s_d.treq[i]   = 1'b1;
                s_d.twe[i]    = m_we_i[k];
                s_d.taddr[i]  = m_addr_i[k];
                s_d.twdata[i] = m_wdata_i[k];
                s_d.tsrc[i]   = k;
            end
            if (ack[i])
            begin
                s_d.treq[i]             = 1'b0;
                s_d.done[s_q.tsrc[i]]   = 1'b1;
                s_d.rdata[s_q.tsrc[i]]  = trdata[i];
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            s_q <= TOP_RST;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign m_done_o    = s_q.done;
    assign m_err_o     = s_q.err;
    assign m_rdata_o   = s_q.rdata;
    assign page_en_o   = s_q.page_en;
    assign page_base_o = s_q.page_base;
    assign mem_gnt_o   = gnt;
    assign sys_req_o   = s_q.treq[T_MEM];
    assign sys_we_o    = s_q.twe[T_MEM];
    assign sys_addr_o  = s_q.taddr[T_MEM];
    assign sys_wdata_o = s_q.twdata[T_MEM];
    assign per_ce_o    = s_q.pce;
    assign per_req_o   = s_q.treq[T_PER];
    assign per_we_o    = s_q.twe[T_PER];
    assign per_addr_o  = s_q.taddr[T_PER];
    assign per_wdata_o = s_q.twdata[T_PER];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_NO_HOST_PER: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        s_q.treq[T_PER] |-> s_q.tsrc[T_PER] != 2'(M_HOST))
        else $error("Host port reached a peripheral.");

    AST_SYS_SRC: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        s_q.treq[T_MEM] |-> s_q.tsrc[T_MEM] inside {2'(M_HOST), 2'(M_ACCEL)})
        else $error("System memory port carried a CPU access.");

    AST_PAGE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ($rose(s_q.treq[T_MEM]) && s_q.tsrc[T_MEM] == 2'(M_HOST) && $past(s_q.page_en, 2))
        |-> s_q.taddr[T_MEM][PAGE_MSB:PAGE_LSB] == $past(s_q.page_base, 2))
        else $error("Host access outside its page reached memory.");

    AST_PAGE_CPU: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ($changed(s_q.page_base) || $changed(s_q.page_en))
        |-> ($past(page_we_i) || !$past(nrst_i)))
        else $error("Host page changed without a CPU write.");

    AST_PER_CE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ($fell(s_q.treq[T_PER]) && $past(nrst_i)) |-> $past(s_q.pce))
        else $error("Peripheral transfer ended off the peripheral enable.");

    AST_PARALLEL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (ack[T_MEM] && ack[T_PER]) |=> $countones(s_q.done) == 2)
        else $error("Parallel transfers did not both complete.");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on refusals

    AST_HOST_PER_ERR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (req_eff[M_HOST] && is_per[M_HOST]) |=> s_q.err[M_HOST])
        else $error("Host port request to a peripheral was not refused.");

    AST_CPU_MEM_ERR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (req_eff[M_CPU] && !is_per[M_CPU]) |=> s_q.err[M_CPU])
        else $error("CPU request to memory was not refused.");

    AST_PAGE_ERR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (req_eff[M_HOST] && !in_page && !own[T_MEM][M_HOST]) |=> s_q.err[M_HOST])
        else $error("Host request outside its page was not refused.");

    AST_ERR_PULSE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.err & s_d.err) == '0)
        else $error("Refusal pulse lasted more than one cycle.");

    AST_DONE_ERR: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.done & s_q.err) == '0)
        else $error("Master saw completion and refusal together.");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on transfers in flight

    AST_SYS_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.treq[T_MEM] && !ack[T_MEM])
        |=> (s_q.treq[T_MEM] && $stable(s_q.taddr[T_MEM])))
        else $error("Memory transfer changed before completion.");

    AST_PER_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.treq[T_PER] && !ack[T_PER])
        |=> (s_q.treq[T_PER] && $stable(s_q.taddr[T_PER])))
        else $error("Peripheral transfer changed before completion.");

    AST_MEM_ACK: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ack[T_MEM] |=> !s_q.treq[T_MEM])
        else $error("System port request stayed after its grant.");

    AST_SYS_GRANT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(s_q.treq[T_MEM]) |=> gnt[SRC_SYS])
        else $error("System port request not granted in time.");

    AST_DONE_PULSE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.done & s_d.done) == '0)
        else $error("Completion pulse lasted more than one cycle.");

    AST_RDATA_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (ack == '0) |=> $stable(s_q.rdata))
        else $error("Read data changed without a completion.");

    AST_PER_START: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $rose(s_q.treq[T_PER]) |-> $past(s_q.pce, 2))
        else $error("Peripheral transfer started off the peripheral enable.");

    AST_PCE_GAP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (PDIV > 1 && s_q.pce) |=> !s_q.pce)
        else $error("Peripheral enable lasted more than one cycle.");

    AST_PARALLEL_GO: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (start[T_MEM] && start[T_PER]) |=> s_q.treq == 2'h3)
        else $error("Parallel transfers did not both start.");

endmodule

/* File: hdl/xbpa_memsel.sv */
`timescale 1ns/1ps
module xbpa_memsel
    import xbpa_pkg::*;
(
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    input  wire logic [MEM_SRCS-1:0] req_i,
    output logic      [MEM_SRCS-1:0] gnt_o
);

    xbpa_mem_st_t s_q;
    xbpa_mem_st_t s_d;

    // Lower source index wins; a source granted last cycle is not granted again.
    always_comb
    begin
        int cnt;
        cnt = 0;
        s_d = MEM_RST;
        for (int i = 0; i < MEM_SRCS; i++)
        begin
            if (req_i[i] && !s_q.gnt[i] && cnt < MEM_SLOTS)
            begin
                s_d.gnt[i] = 1'b1;
                cnt = cnt + 1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            s_q <= MEM_RST;
        else
            s_q <= s_d;
    end

    assign gnt_o = s_q.gnt;

    AST_MEM_SLOTS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $countones(s_q.gnt) <= MEM_SLOTS)
        else $error("More than three memory grants in one cycle.");

    AST_MEM_CAUSE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.gnt & ~$past(req_i)) == '0)
        else $error("Memory grant without a request.");

    AST_MEM_SINGLE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (req_i[SRC_DA] && !s_q.gnt[SRC_DA] && $countones(req_i) <= MEM_SLOTS)
        |=> s_q.gnt[SRC_DA])
        else $error("Unconflicted CPU data access not granted in one cycle.");

endmodule

/* File: hdl/xbpa_pkg.sv */
package xbpa_pkg;

    localparam int NM      = 3;
    localparam int NT      = 2;
    localparam int M_CPU   = 0;
    localparam int M_HOST  = 1;
    localparam int M_ACCEL = 2;
    localparam int T_MEM   = 0;
    localparam int T_PER   = 1;

    localparam int MEM_SRCS  = 4;
    localparam int MEM_SLOTS = 3;
    localparam int SRC_SYS   = 0;
    localparam int SRC_DA    = 1;
    localparam int SRC_DB    = 2;
    localparam int SRC_FETCH = 3;

    localparam logic [3:0]  PER_REGION    = 4'h4;
    localparam int          PAGE_MSB      = 31;
    localparam int          PAGE_LSB      = 16;
    localparam int          CORE_PERIOD_NS = 8;
    localparam int          PERIPH_DIV    = 2;
    localparam int          DIV_W         = 4;

    typedef enum logic [0:0] {
        ARB_IDLE = 1'b0,
        ARB_HOLD = 1'b1
    } xbpa_arb_state_t;

    typedef struct packed {
        xbpa_arb_state_t st;
        logic [NM-1:0]   own;
        logic            start;
    } xbpa_arb_st_t;

    typedef struct packed {
        logic [MEM_SRCS-1:0] gnt;
    } xbpa_mem_st_t;

    typedef struct packed {
        logic [15:0]           page_base;
        logic                  page_en;
        logic [NM-1:0]         done;
        logic [NM-1:0]         err;
        logic [NM-1:0][31:0]   rdata;
        logic [NT-1:0]         treq;
        logic [NT-1:0]         twe;
        logic [NT-1:0][31:0]   taddr;
        logic [NT-1:0][31:0]   twdata;
        logic [NT-1:0][1:0]    tsrc;
        logic [DIV_W-1:0]      div;
        logic                  pce;
    } xbpa_top_st_t;

    localparam xbpa_arb_st_t ARB_RST = '0;
    localparam xbpa_mem_st_t MEM_RST = '0;
    localparam xbpa_top_st_t TOP_RST = '0;

endpackage

/* File: hdl/xbpa_tgt_arb.sv */
`timescale 1ns/1ps
module xbpa_tgt_arb
    import xbpa_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          nrst_i,
    input  wire logic [NM-1:0] req_i,
    input  wire logic          step_i,
    input  wire logic          done_i,
    output logic      [NM-1:0] own_o,
    output logic               start_o
);

    xbpa_arb_st_t s_q;
    xbpa_arb_st_t s_d;

    // Highest index is the highest priority.
    // accelerator ranks first
    function automatic logic [NM-1:0] pick_top(input logic [NM-1:0] r);
        logic [NM-1:0] g;
        g = '0;
        for (int i = 0; i < NM; i++)
        begin
            if (r[i])
                g = NM'(1) << i;
        end
        return g;
    endfunction

    always_comb
    begin
        s_d = s_q;
        s_d.start = 1'b0;
        case (s_q.st)
            ARB_IDLE:
            begin
                if (step_i && |req_i)
                begin
                    s_d.st = ARB_HOLD;
                    s_d.own = pick_top(req_i);
                    s_d.start = 1'b1;
                end
            end
            ARB_HOLD:
            begin
                if (done_i)
                begin
                    s_d.st = ARB_IDLE;
                    s_d.own = '0;
                end
            end
            default:
            begin
                s_d = ARB_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
            s_q <= ARB_RST;
        else
            s_q <= s_d;
    end

    assign own_o   = s_q.own;
    assign start_o = s_q.start;

    AST_ARB_PRIO: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.st == ARB_IDLE && step_i && req_i[M_ACCEL]) |=> s_q.own == 3'h4)
        else $error("Accelerator lost a contested target.");

    AST_ARB_FIXED: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.st == ARB_IDLE && step_i && req_i[M_HOST] && !req_i[M_ACCEL])
        |=> s_q.own == 3'h2)
        else $error("Host port did not beat the CPU.");

    AST_ARB_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (s_q.st == ARB_HOLD && !done_i) |=> (s_q.st == ARB_HOLD && $stable(s_q.own)))
        else $error("Grant changed before the transfer completed.");

endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb
    import xbpa_pkg::*;
;
    localparam logic [31:0] MEM_KEY = 32'hA5A5_0000;
    localparam logic [31:0] PER_KEY = 32'h0F0F_0000;
    typedef struct packed {logic [1:0] m; logic we; logic [31:0] a; logic e;} xbpa_row_t;
    localparam xbpa_row_t ROWS [8] = '{
        '{2'd2, 1'b0, 32'h0000_0100, 1'b0}, '{2'd2, 1'b1, 32'h0000_0104, 1'b0},
        '{2'd1, 1'b0, 32'h0001_0200, 1'b0}, '{2'd1, 1'b1, 32'h8000_0000, 1'b0},
        '{2'd1, 1'b0, 32'h4000_0000, 1'b1}, '{2'd0, 1'b0, 32'h4000_0010, 1'b0},
        '{2'd0, 1'b0, 32'h0000_0010, 1'b1}, '{2'd2, 1'b1, 32'h4000_0020, 1'b0}};
    localparam logic [31:0] PG_ADDR [4] = '{32'h0002_0000, 32'h0002_FFFC,
                                            32'h0001_FFFC, 32'h0003_0000};

    logic                core_clk_i, nrst_i, set_we, set_en, da, db, fe, per_ack;
    logic [15:0]         set_base, pg_base;
    logic [NM-1:0]       go, cwe, m_done, m_err, ferr;
    logic [NM-1:0][31:0] caddr, m_rdata;
    wire  [NM-1:0]       m_req, m_we;
    wire  [NM-1:0][31:0] m_addr, m_wdata;
    logic [MEM_SRCS-1:0] mem_gnt;
    logic                pg_en, sys_req, sys_we, per_ce, per_req, per_we, sreq_seen;
    logic [31:0]         sys_addr, sys_wdata, per_addr, per_wdata, last_wd, pa;
    logic [31:0]         frd [NM];
    int                  fin [NM];
    int                  cyc, num_errors, total_checks, pwait, pcnt, n, t0;

    wire [31:0] sys_rdata = sys_addr ^ MEM_KEY;
    wire [31:0] per_rdata = per_ack ? per_addr ^ PER_KEY : ~(per_addr ^ PER_KEY);

    xbpa_crossbar #(.PDIV(2)) xbpa_crossbar_i (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .m_req_i(m_req), .m_we_i(m_we),
        .m_addr_i(m_addr), .m_wdata_i(m_wdata), .m_done_o(m_done), .m_err_o(m_err),
        .m_rdata_o(m_rdata), .page_we_i(set_we), .page_en_i(set_en),
        .page_base_i(set_base), .page_en_o(pg_en), .page_base_o(pg_base),
        .cpu_da_req_i(da), .cpu_db_req_i(db), .fetch_req_i(fe), .mem_gnt_o(mem_gnt),
        .sys_req_o(sys_req), .sys_we_o(sys_we), .sys_addr_o(sys_addr),
        .sys_wdata_o(sys_wdata), .sys_rdata_i(sys_rdata), .per_ce_o(per_ce),
        .per_req_o(per_req), .per_we_o(per_we), .per_addr_o(per_addr),
        .per_wdata_o(per_wdata), .per_ack_i(per_ack), .per_rdata_i(per_rdata));

    for (genvar k = 0; k < NM; k++)
    begin : g_m
        xbpa_master_mdl xbpa_master_mdl_i (
            .core_clk_i(core_clk_i), .nrst_i(nrst_i), .go_i(go[k]), .we_i(cwe[k]),
            .addr_i(caddr[k]), .done_i(m_done[k]), .err_i(m_err[k]), .req_o(m_req[k]),
            .we_o(m_we[k]), .addr_o(m_addr[k]), .wdata_o(m_wdata[k]));
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Peripheral target acknowledges after pwait cycles of a standing request.
    always @(posedge core_clk_i)
    begin
        #1;
        pcnt = per_req ? pcnt + 1 : 0;
        per_ack = per_req && pcnt > pwait;
    end

    always @(posedge core_clk_i)
    begin
        #2;
        cyc++;
        for (int k = 0; k < NM; k++)
            if (m_done[k] | m_err[k])
            begin
                fin[k] = cyc;
                ferr[k] = m_err[k];
                frd[k] = m_rdata[k];
            end
        if (per_ack && per_ce && per_we)
            last_wd = per_wdata;
        if (mem_gnt[SRC_SYS] && sys_we)
            last_wd = sys_wdata;
        sreq_seen = sreq_seen | sys_req;
        chk($countones(mem_gnt) <= MEM_SLOTS, 1, "grant count");
        if (cyc == 3000)
        begin
            num_errors++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [31:0] xrd(input logic [31:0] a);
        return a ^ ((a[31:28] == PER_REGION) ? PER_KEY : MEM_KEY);
    endfunction

    task automatic put(input int m, input logic we, input logic [31:0] a);
        cwe[m] = we;
        caddr[m] = a;
    endtask

    task automatic fire(input logic [NM-1:0] mask);
        for (int k = 0; k < NM; k++)
            if (mask[k])
                fin[k] = 0;
        go = mask;
        @(posedge core_clk_i);
        #1;
        go = '0;
    endtask

    task automatic wait_fin(input logic [NM-1:0] mask);
        for (int k = 0; k < NM; k++)
        begin
            for (int i = 0; i < 200 && mask[k] && fin[k] == 0; i++)
                @(posedge core_clk_i);
            if (mask[k])
                chk(fin[k] != 0, 1, "transfer finished");
        end
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic contest(input logic [NM-1:0] mask, input int win, input int lose,
                           input logic [31:0] a);
        put(win, 1'b0, a);
        put(lose, 1'b0, a + 32'h0000_0004);
        fire(mask);
        wait_fin(mask);
        chk(fin[win] < fin[lose], 1, "priority order");
        chk(frd[lose], xrd(a + 32'h0000_0004), "loser data");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {nrst_i, set_we, set_en, da, db, fe, sreq_seen} = '0;
        {go, cwe, caddr, set_base} = '0;
        {num_errors, total_checks, pwait} = '0;
        repeat (10) @(posedge core_clk_i);
        #1;
        chk({pg_en, pg_base, m_done, m_err, sys_req, per_req}, '0, "reset outputs");
        repeat (10) @(posedge core_clk_i);
        #1;
        nrst_i = 1'b1;
        foreach (ROWS[i])
        begin
            put(ROWS[i].m, ROWS[i].we, ROWS[i].a);
            fire(NM'(1) << ROWS[i].m);
            wait_fin(NM'(1) << ROWS[i].m);
            chk(ferr[ROWS[i].m], ROWS[i].e, "refusal");
            if (!ROWS[i].e)
                chk(ROWS[i].we ? last_wd : frd[ROWS[i].m],
                    ROWS[i].we ? ~ROWS[i].a : xrd(ROWS[i].a), "data");
        end
        da = 1'b1;
        @(posedge core_clk_i);
        #1;
        da = 1'b0;
        chk(mem_gnt, 4'b0010, "data A grant");
        put(M_HOST, 1'b0, 32'h0000_0040);
        {da, db, fe} = 3'b111;
        fire(3'b010);
        n = 0;
        repeat (12)
        begin
            @(posedge core_clk_i);
            #1;
            if (mem_gnt[SRC_FETCH] === 1'b1)
                n++;
        end
        {da, db, fe} = 3'b000;
        wait_fin(3'b010);
        chk(n > 0, 1, "fetch served");
        chk(frd[M_HOST], 32'h0000_0040 ^ MEM_KEY, "system port data");
        pwait = 3;
        contest(3'b110, M_ACCEL, M_HOST, 32'h0000_0800);
        contest(3'b101, M_ACCEL, M_CPU, 32'h4000_0100);
        pwait = 8;
        put(M_ACCEL, 1'b1, 32'h4000_0200);
        put(M_HOST, 1'b0, 32'h0000_0300);
        t0 = cyc;
        fire(3'b110);
        wait_fin(3'b110);
        chk(fin[M_HOST] - t0 <= 8, 1, "parallel latency");
        chk(fin[M_HOST] < fin[M_ACCEL], 1, "parallel order");
        pwait = 6;
        put(M_CPU, 1'b0, 32'h4000_0300);
        put(M_ACCEL, 1'b0, 32'h4000_0304);
        fire(3'b001);
        repeat (3) @(posedge core_clk_i);
        #1;
        fire(3'b100);
        wait_fin(3'b101);
        chk(fin[M_CPU] < fin[M_ACCEL], 1, "grant held");
        chk(frd[M_CPU], xrd(32'h4000_0300), "held data");
        {set_en, set_base, set_we} = {1'b1, 16'h0002, 1'b1};
        @(posedge core_clk_i);
        #1;
        set_we = 1'b0;
        chk({pg_en, pg_base}, 17'h1_0002, "page setting");
        for (int i = 0; i < 4; i++)
        begin
            pa = PG_ADDR[i];
            put(M_HOST, 1'b1, pa);
            sreq_seen = 1'b0;
            fire(3'b010);
            wait_fin(3'b010);
            chk(ferr[M_HOST], pa[31:16] != 16'h0002, "page refusal");
            chk(sreq_seen, pa[31:16] == 16'h0002, "page memory reach");
        end
        chk({pg_en, pg_base}, 17'h1_0002, "page after host writes");
        nrst_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk({pg_en, pg_base}, 17'h0_0000, "page after reset");
        nrst_i = 1'b1;
        close_out();
    end
endmodule

/* File: test/xbpa_master_mdl.sv */
`timescale 1ns/1ps
module xbpa_master_mdl
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        go_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        done_i,
    input  wire logic        err_i,
    output logic             req_o,
    output logic             we_o,
    output logic      [31:0] addr_o,
    output logic      [31:0] wdata_o
);
    logic        fin;
    logic        g;
    logic        w;
    logic [31:0] a;

    initial
    begin
        req_o   = 1'b0;
        we_o    = 1'b0;
        addr_o  = 32'h0000_0000;
        wdata_o = 32'h0000_0000;
        fin     = 1'b0;
    end

    // The request drops in the cycle after its pulse; released address and write-data lines show the inverse value, we_o holds.
    always @(posedge core_clk_i)
    begin
        g = go_i;
        w = we_i;
        a = addr_i;
        #1;
        if (!nrst_i || fin)
        begin
            req_o   = 1'b0;
            addr_o  = ~addr_o;
            wdata_o = ~wdata_o;
        end
        else if (g && !req_o)
        begin
            req_o   = 1'b1;
            we_o    = w;
            addr_o  = a;
            wdata_o = ~a;
        end
        fin = req_o && (done_i || err_i);
    end
endmodule
